// ===== hdl/osct_regs.svh
`ifndef OSCT_REGS_SVH
`define OSCT_REGS_SVH
// ----------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------
`define OSCT_ADDR_TUNE     2'h0
`define OSCT_ADDR_CTRL     2'h1
`define OSCT_ADDR_CTRL2    2'h2
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OSCT_TUNE_SRC_BIT  7
`define OSCT_TUNE_PLL_BIT  6
`define OSCT_TUNE_TRIM_MSB 5
`define OSCT_CTRL_IFS_LSB  4
`define OSCT_CTRL_SCS_LSB  0
`define OSCT_CTRL2_MF_BIT  0
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OSCT_TUNE_RST      8'h00
`define OSCT_IFS_RST       3'h3
`define OSCT_SCS_RST       2'h0
`define OSCT_MF_RST        1'b0
// ----------------------------------------------------------------
// Mode codes and divider shape
// ----------------------------------------------------------------
`define OSCT_MODE_INTIO    4'h8
`define OSCT_MODE_INTCLK   4'h9
`define OSCT_HF_DIV_BITS   9
`define OSCT_MF_DIV_BITS   4
`define OSCT_PLL_CNT_W     16
`define OSCT_PLL_SHIFT     2
`endif

// ===== hdl/osct_pkg.sv
// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package osct_pkg;
  // System clock source select
  typedef enum logic [1:0] {
    OSCT_SCS_PRI  = 2'b00,
    OSCT_SCS_SEC  = 2'b01,
    OSCT_SCS_INT  = 2'b10,
    OSCT_SCS_INT2 = 2'b11
  } osct_scs_t;
  // Internal frequency select codes
  typedef enum logic [2:0] {
    OSCT_F16M = 3'b111,
    OSCT_F8M  = 3'b110,
    OSCT_F4M  = 3'b101,
    OSCT_F2M  = 3'b100,
    OSCT_F1M  = 3'b011,
    OSCT_F500 = 3'b010,
    OSCT_F250 = 3'b001,
    OSCT_F31  = 3'b000
  } osct_freq_t;
  // Whole state of the top module
  typedef struct packed {
    logic [7:0] tune;      // Tuning register
    logic [2:0] ifs;       // Internal frequency select
    logic [1:0] scs;       // System clock select
    logic       mfsel;     // Mid oscillator select
    logic [7:0] rdata;     // Read data
    logic       sys_en;    // System clock tick
    logic       int_en;    // Internal clock tick
    logic       lf_en;     // Low frequency tick
    logic [1:0] qcnt;      // Quarter divider
    logic       qclk;      // Quarter clock level
    logic       out_oe;    // Output pin drive
    logic       out_gpio;  // Output pin released
    logic       in_gpio;   // Input pin released
    logic       pll_on;    // Multiplier enabled
  } osct_state_t;
endpackage

// ===== hdl/osct_tap_div.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Binary tap divider: tap k pulses once per 2**k input ticks
// ----------------------------------------------------------------
module osct_tap_div #(
  parameter int N = 4
) (
  input  wire logic         CLK,     // Clock
  input  wire logic         RST_N,   // Async reset, low
  input  wire logic         tick_in, // Oscillator tick
  output logic      [N:0]   taps     // Divided ticks
);
  typedef struct packed {
    logic [N-1:0] cnt;               // Tick counter
  } osct_div_state_t;
  osct_div_state_t st_r;             // State
  osct_div_state_t st_nxt;           // Next state
  // Refuse a divider with no stages
  if (N < 1) begin : g_chk
    $error("osct_tap_div needs N >= 1");
  end
  // Tap 0 is the undivided tick
  assign taps[0] = tick_in;
  // One tap per stage; a tap fires on the tick that wraps its stages
  for (genvar k = 1; k <= N; k++) begin : g_tap
    assign taps[k] = tick_in & (&st_r.cnt[k-1:0]);
  end
  // Count ticks
  always_comb begin
    st_nxt = st_r;
    if (tick_in) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end
  // Register state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/osct_pll_x4.sv
`timescale 1ns/1ps
`default_nettype none
`include "osct_regs.svh"
// ----------------------------------------------------------------
// Times-four multiplier on tick enables: measures the last input
// period and spreads four output ticks across the next one
// ----------------------------------------------------------------
module osct_pll_x4 #(
  parameter int W = `OSCT_PLL_CNT_W
) (
  input  wire logic CLK,       // Clock
  input  wire logic RST_N,     // Async reset, low
  input  wire logic ref_tick,  // Input clock tick
  input  wire logic enable,    // Multiplier on
  output logic      out_tick   // Multiplied tick
);
  typedef struct packed {
    logic [W-1:0] cnt;         // Cycles since last tick
    logic [W-1:0] quarter;     // Output spacing
    logic [W-1:0] sub;         // Spacing counter
    logic [1:0]   left;        // Ticks still to emit
    logic         out;         // Output tick
  } osct_pll_state_t;
  osct_pll_state_t st_r;       // State
  osct_pll_state_t st_nxt;     // Next state
  logic [W-1:0]    per;        // Measured period
  // Needs room for a period of at least four cycles
  if (W < 3) begin : g_chk
    $error("osct_pll_x4 needs W >= 3");
  end
  assign out_tick = st_r.out;
  assign per = st_r.cnt + 1'b1;
  // Period measure and tick spreading
  always_comb begin
    st_nxt = st_r;
    st_nxt.out = 1'b0;
    if (ref_tick) begin
      // First of four ticks lands on the input edge
      st_nxt.cnt = '0;
      st_nxt.quarter = per >> `OSCT_PLL_SHIFT;
      st_nxt.sub = '0;
      st_nxt.left = 2'h3;
      st_nxt.out = enable;
    end else begin
      // Saturate so a stopped input cannot wrap the measure
      if (~&st_r.cnt) begin
        st_nxt.cnt = per;
      end
      if (st_r.left != 2'h0) begin
        if (st_r.sub + 1'b1 >= st_r.quarter) begin
          st_nxt.sub = '0;
          st_nxt.left = st_r.left - 1'b1;
          st_nxt.out = enable;
        end else begin
          st_nxt.sub = st_r.sub + 1'b1;
        end
      end
    end
  end
  // Register state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  pll_edge_tick_a: assert property (ref_tick && enable |=> out_tick)
    else $error("multiplier missed tick on input edge");
  pll_off_quiet_a: assert property (!enable |=> !out_tick)
    else $error("multiplier ticked while off");
endmodule
`default_nettype wire

// ===== hdl/osct_clock_ctrl.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "osct_regs.svh"
// Summary of operation
// - Two internal modes: pin free or clock/4
// - Internal modes release the input pin
// - Trim is signed six bits, resets zero
// - Trim steers only high and mid oscillators
// - Trim applies at once, no done flag
// - Low frequency oscillator ignores trim entirely
// - Bit 7 picks divided or direct 31k
// - Bit 6 enables times-four multiplier everywhere
// - Low oscillator clocks timers and monitor
// - Divider taps plus low oscillator muxed out
// - Select field, mid bit, source bit choose
// - Eight frequencies, one megahertz after reset
// - 500k/250k from mid or high oscillator
// - External modes: either enable bit starts multiplier
// - Multiplier output is four times input
// - Internal modes: software bit alone controls multiplier
// - High oscillator times four reaches 64 MHz
// - Source select 00 primary, 01 secondary, 10 internal
module osct_clock_ctrl
  import osct_pkg::*;
(
  input  wire logic       CLK,          // 200 MHz clock
  input  wire logic       RST_N,        // Async reset, low
  input  wire logic [1:0] REG_ADDR,     // Register address
  input  wire logic [7:0] REG_WDATA,    // Write data
  input  wire logic       REG_WR,       // Write strobe
  input  wire logic       REG_RD,       // Read strobe
  output logic      [7:0] REG_RDATA,    // Read data, next cycle
  input  wire logic [3:0] OSC_MODE_CFG, // Oscillator mode config
  input  wire logic       PLL_CFG_EN,   // Multiplier config bit
  input  wire logic       HF_OSC_TICK,  // High oscillator tick
  input  wire logic       MF_OSC_TICK,  // Mid oscillator tick
  input  wire logic       LF_OSC_TICK,  // Low oscillator tick
  input  wire logic       EXT_OSC_TICK, // External oscillator tick
  input  wire logic       SEC_OSC_TICK, // Secondary oscillator tick
  output logic      [5:0] TRIM_HF,      // Trim to high oscillator
  output logic      [5:0] TRIM_MF,      // Trim to mid oscillator
  output logic            SYS_CLK_EN,   // System clock tick
  output logic            INT_CLK_EN,   // Internal clock tick
  output logic            LF_TIMER_EN,  // Tick for timers, monitor
  output logic            PLL_ACTIVE,   // Multiplier running
  output logic            OSC_OUT_O,    // Output pin level
  output logic            OSC_OUT_OE,   // Output pin drive
  output logic            OSC_OUT_GPIO, // Output pin given to I/O
  output logic            OSC_IN_GPIO   // Input pin given to I/O
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  osct_state_t                  st_r;       // State
  osct_state_t                  st_nxt;     // Next state
  logic [`OSCT_HF_DIV_BITS:0]   hf_taps;    // High oscillator taps
  logic [`OSCT_MF_DIV_BITS:0]   mf_taps;    // Mid oscillator taps
  logic                         int_mode;   // Internal primary mode
  logic                         int_sel;    // Internal clock tick
  logic                         lf_div_sel; // Divided 31k tick
  logic                         pri_tick;   // Primary tick, raw
  logic                         pri_eff;    // Primary after multiplier
  logic                         pll_tick;   // Multiplier output
  logic                         pll_want;   // Multiplier enable
  logic                         sys_sel;    // Chosen system tick
  logic                         trim_src;   // Source select bit
  logic                         trim_pll;   // Software enable bit

  // ----------------------------------------------------------------
  // Divider chains
  // ----------------------------------------------------------------
  // High oscillator: 16 MHz down to 31.25 kHz in binary steps
  osct_tap_div #(
    .N       (`OSCT_HF_DIV_BITS)
  ) u_hf_div (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .tick_in (HF_OSC_TICK),
    .taps    (hf_taps)
  );
  // Mid oscillator: 500 kHz down to 31.25 kHz
  osct_tap_div #(
    .N       (`OSCT_MF_DIV_BITS)
  ) u_mf_div (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .tick_in (MF_OSC_TICK),
    .taps    (mf_taps)
  );

  // ----------------------------------------------------------------
  // Times-four multiplier on the primary source
  // ----------------------------------------------------------------
  osct_pll_x4 #(
    .W        (`OSCT_PLL_CNT_W)
  ) u_pll (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .ref_tick (pri_tick),
    .enable   (pll_want),
    .out_tick (pll_tick)
  );

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  assign trim_src = st_r.tune[`OSCT_TUNE_SRC_BIT];
  assign trim_pll = st_r.tune[`OSCT_TUNE_PLL_BIT];

  // Both internal modes make the oscillator block the primary clock
  assign int_mode = (OSC_MODE_CFG == `OSCT_MODE_INTIO) ||
                    (OSC_MODE_CFG == `OSCT_MODE_INTCLK);

  // Divided 31k comes from mid or high, following the mid select
  assign lf_div_sel = st_r.mfsel ? mf_taps[`OSCT_MF_DIV_BITS]
                                 : hf_taps[`OSCT_HF_DIV_BITS];

  // Frequency mux; select field, mid bit and source bit combine
  always_comb begin
    int_sel = 1'b0;
    unique case (osct_freq_t'(st_r.ifs))
      OSCT_F16M: begin
        int_sel = hf_taps[0];
      end
      OSCT_F8M: begin
        int_sel = hf_taps[1];
      end
      OSCT_F4M: begin
        int_sel = hf_taps[2];
      end
      OSCT_F2M: begin
        int_sel = hf_taps[3];
      end
      OSCT_F1M: begin
        int_sel = hf_taps[4];
      end
      OSCT_F500: begin
        // Mid raw, or high divided by 32
        int_sel = st_r.mfsel ? mf_taps[0] : hf_taps[5];
      end
      OSCT_F250: begin
        int_sel = st_r.mfsel ? mf_taps[1] : hf_taps[6];
      end
      OSCT_F31: begin
        // Direct low oscillator unless the source bit asks otherwise
        int_sel = trim_src ? lf_div_sel : LF_OSC_TICK;
      end
    endcase
  end

  // Primary source: oscillator block in internal modes, else pins
  assign pri_tick = int_mode ? int_sel : EXT_OSC_TICK;

  // Internal modes ignore the config bit; external modes use either
  assign pll_want = int_mode ? trim_pll
                             : (trim_pll | PLL_CFG_EN);

  // The multiplier replaces the primary tick while enabled
  assign pri_eff = pll_want ? pll_tick : pri_tick;

  // System clock select
  always_comb begin
    sys_sel = 1'b0;
    unique case (osct_scs_t'(st_r.scs))
      OSCT_SCS_PRI: begin
        sys_sel = pri_eff;
      end
      OSCT_SCS_SEC: begin
        sys_sel = SEC_OSC_TICK;
      end
      OSCT_SCS_INT, OSCT_SCS_INT2: begin
        // Upper code behaves as the internal block
        sys_sel = int_sel;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state: registers, pins and clock ticks
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Register writes; the trim reaches the oscillators next cycle
    // and there is deliberately no settle flag
    if (REG_WR) begin
      unique case (REG_ADDR)
        `OSCT_ADDR_TUNE: begin
          st_nxt.tune = REG_WDATA;
        end
        `OSCT_ADDR_CTRL: begin
          st_nxt.ifs = REG_WDATA[`OSCT_CTRL_IFS_LSB +: 3];
          st_nxt.scs = REG_WDATA[`OSCT_CTRL_SCS_LSB +: 2];
        end
        `OSCT_ADDR_CTRL2: begin
          st_nxt.mfsel = REG_WDATA[`OSCT_CTRL2_MF_BIT];
        end
        default: begin
          // Unmapped write is dropped
        end
      endcase
    end
    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `OSCT_ADDR_TUNE: begin
          st_nxt.rdata = st_r.tune;
        end
        `OSCT_ADDR_CTRL: begin
          st_nxt.rdata[`OSCT_CTRL_IFS_LSB +: 3] = st_r.ifs;
          st_nxt.rdata[`OSCT_CTRL_SCS_LSB +: 2] = st_r.scs;
        end
        `OSCT_ADDR_CTRL2: begin
          st_nxt.rdata[`OSCT_CTRL2_MF_BIT] = st_r.mfsel;
        end
        default: begin
          // Unmapped reads return zero
        end
      endcase
    end
    // Clock ticks, one register stage each
    st_nxt.sys_en = sys_sel;
    st_nxt.int_en = int_sel;
    // Timers see the raw low oscillator, never trimmed
    st_nxt.lf_en = LF_OSC_TICK;
    st_nxt.pll_on = pll_want;
    // System clock over four: toggles every second system tick
    if (sys_sel) begin
      st_nxt.qcnt = st_r.qcnt + 1'b1;
    end
    st_nxt.qclk = st_nxt.qcnt[1];
    // Pin ownership follows the mode config
    st_nxt.out_oe = (OSC_MODE_CFG == `OSCT_MODE_INTCLK);
    st_nxt.out_gpio = (OSC_MODE_CFG == `OSCT_MODE_INTIO);
    st_nxt.in_gpio = int_mode;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
      st_r.tune <= `OSCT_TUNE_RST;
      st_r.ifs <= `OSCT_IFS_RST;
      st_r.scs <= `OSCT_SCS_RST;
      st_r.mfsel <= `OSCT_MF_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  // Same trim word to both tunable oscillators, none to low one
  assign TRIM_HF = st_r.tune[`OSCT_TUNE_TRIM_MSB:0];
  assign TRIM_MF = st_r.tune[`OSCT_TUNE_TRIM_MSB:0];
  assign REG_RDATA = st_r.rdata;
  assign SYS_CLK_EN = st_r.sys_en;
  assign INT_CLK_EN = st_r.int_en;
  assign LF_TIMER_EN = st_r.lf_en;
  assign PLL_ACTIVE = st_r.pll_on;
  assign OSC_OUT_O = st_r.qclk;
  assign OSC_OUT_OE = st_r.out_oe;
  assign OSC_OUT_GPIO = st_r.out_gpio;
  assign OSC_IN_GPIO = st_r.in_gpio;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  tune_write_a: assert property (REG_WR && REG_ADDR == `OSCT_ADDR_TUNE |=>
      TRIM_HF == $past(REG_WDATA[5:0]) && TRIM_MF == $past(REG_WDATA[5:0]))
    else $error("trim did not follow tuning write");

  tune_read_a: assert property (REG_RD && REG_ADDR == `OSCT_ADDR_TUNE && !REG_WR |=>
      REG_RDATA == {$past(st_r.tune[7:6]), $past(TRIM_HF)})
    else $error("tuning read back wrong");

  lf_untrimmed_a: assert property (LF_TIMER_EN == $past(LF_OSC_TICK))
    else $error("timer tick not the raw low oscillator");

  quarter_clock_out_pin_a: assert property (OSC_MODE_CFG == `OSCT_MODE_INTCLK |=>
      OSC_OUT_OE && !OSC_OUT_GPIO && OSC_IN_GPIO)
    else $error("clock out mode pin setup wrong");

  gpio_pin_a: assert property (OSC_MODE_CFG == `OSCT_MODE_INTIO |=>
      !OSC_OUT_OE && OSC_OUT_GPIO && OSC_IN_GPIO)
    else $error("I/O mode pin setup wrong");

  pll_internal_a: assert property (int_mode |=> PLL_ACTIVE == $past(trim_pll))
    else $error("config bit steered multiplier in internal mode");

  pll_external_a: assert property (!int_mode |=>
      PLL_ACTIVE == ($past(trim_pll) || $past(PLL_CFG_EN)))
    else $error("external multiplier enable wrong");

  f16_direct_a: assert property (st_r.ifs == 3'b111 |=> INT_CLK_EN == $past(HF_OSC_TICK))
    else $error("16 MHz select not the high oscillator");

  lf_direct_a: assert property (st_r.ifs == 3'b000 && !trim_src |=>
      INT_CLK_EN == $past(LF_OSC_TICK))
    else $error("31k select not the low oscillator");

  sec_select_a: assert property (st_r.scs == 2'b01 |=> SYS_CLK_EN == $past(SEC_OSC_TICK))
    else $error("secondary select not followed");

  // Outside the internal modes both pins stay with the oscillator
  ext_pins_a: assert property (!int_mode |=>
      !OSC_OUT_OE && !OSC_OUT_GPIO && !OSC_IN_GPIO)
    else $error("external mode pin setup wrong");

  // Read port idles at zero so a late capture cannot see stale data
  rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data stood without a strobe");

  // Quarter clock moves only on system ticks
  quarter_hold_a: assert property (!sys_sel |=> $stable(OSC_OUT_O))
    else $error("quarter clock moved without a system tick");

  // Mid select feeds the 500 kHz choice undivided
  mid_500k_a: assert property (st_r.ifs == 3'b010 && st_r.mfsel |=>
      INT_CLK_EN == $past(MF_OSC_TICK))
    else $error("500 kHz select not the mid oscillator");

  // While multiplied, the primary path carries only multiplier ticks
  pll_primary_a: assert property (pll_want && st_r.scs == 2'b00 |=>
      SYS_CLK_EN == $past(pll_tick))
    else $error("primary path bypassed the multiplier");

  pll_cov_c: cover property (PLL_ACTIVE && SYS_CLK_EN);
  quarter_clock_out_cov_c: cover property (OSC_OUT_OE && $rose(OSC_OUT_O));
  lf_div_cov_c: cover property (st_r.ifs == 3'b000 && trim_src && INT_CLK_EN);
  mf_cov_c: cover property (st_r.mfsel && st_r.ifs == 3'b010 && INT_CLK_EN);
  int_pll_cov_c: cover property (int_mode && PLL_ACTIVE && SYS_CLK_EN);
endmodule
`default_nettype wire

// ===== sim/osct_clock_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "osct_regs.svh"
module osct_clock_ctrl_test
  import osct_pkg::*;
;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic       CLK, RST_N, REG_WR, REG_RD, PLL_CFG_EN;       // Clock, reset, strobes
  logic [1:0] REG_ADDR;                                     // Register address
  logic [7:0] REG_WDATA, REG_RDATA, tune_v;                 // Bus data, last tune
  logic       q_v;                                          // Quarter clock before ticks
  logic [3:0] OSC_MODE_CFG;                                 // Mode config
  logic [4:0] tk;                                           // Ticks: HF MF LF EXT SEC
  logic [5:0] TRIM_HF, TRIM_MF;                             // Trim outputs
  logic       SYS_CLK_EN, INT_CLK_EN, LF_TIMER_EN, PLL_ACTIVE;
  logic       OSC_OUT_O, OSC_OUT_OE, OSC_OUT_GPIO, OSC_IN_GPIO;
  int         err_count, checks, ni, ns;                    // Tallies and tick counts
  logic [3:0] modes [3] = '{4'h0, `OSCT_MODE_INTIO, `OSCT_MODE_INTCLK};
  int         src [3] = '{3, 4, 0};                         // Tick index per sys select
  int         bad [3] = '{4, 3, 3};                         // Tick that must not pass

  osct_clock_ctrl uut (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .OSC_MODE_CFG(OSC_MODE_CFG),
    .PLL_CFG_EN(PLL_CFG_EN), .HF_OSC_TICK(tk[0]), .MF_OSC_TICK(tk[1]), .LF_OSC_TICK(tk[2]),
    .EXT_OSC_TICK(tk[3]), .SEC_OSC_TICK(tk[4]), .TRIM_HF(TRIM_HF), .TRIM_MF(TRIM_MF),
    .SYS_CLK_EN(SYS_CLK_EN), .INT_CLK_EN(INT_CLK_EN), .LF_TIMER_EN(LF_TIMER_EN),
    .PLL_ACTIVE(PLL_ACTIVE), .OSC_OUT_O(OSC_OUT_O), .OSC_OUT_OE(OSC_OUT_OE),
    .OSC_OUT_GPIO(OSC_OUT_GPIO), .OSC_IN_GPIO(OSC_IN_GPIO));

  // Free-running 200 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Case equality so an unknown never matches
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask

  // One cycle of tick stimulus; counts the design's tick outputs once settled
  task automatic step(input logic [4:0] t);
    @(posedge CLK);
    tk <= t;
    #1;
    ni += int'(INT_CLK_EN === 1'b1);
    ns += int'(SYS_CLK_EN === 1'b1);
  endtask

  // n ticks on source b, gap cycles apart, then d idle cycles
  task automatic run(input int b, input int n, input int gap, input int d);
    ni = 0;
    ns = 0;
    repeat (n) begin
      step(5'(1 << b));
      repeat (gap - 1) step(5'h0);
    end
    repeat (d) step(5'h0);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, exp);
  endtask

  // Hang guard: a run past this bound is a failure
  initial begin
    repeat (100000) @(posedge CLK);
    err_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {RST_N, REG_WR, REG_RD, PLL_CFG_EN, REG_ADDR, REG_WDATA, OSC_MODE_CFG, tk} = '0;
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    void'($urandom(27309));
    // Reset values, unmapped read gives zero
    rd(`OSCT_ADDR_TUNE, 8'h00);
    rd(`OSCT_ADDR_CTRL, {1'b0, OSCT_F1M, 4'h0});
    rd(`OSCT_ADDR_CTRL2, 8'h00);
    rd(2'h3, 8'h00);
    // Trim corners then random words; low oscillator tick must pass untouched
    for (int i = 0; i < 10; i++) begin
      tune_v = (i == 0) ? 8'h1f : (i == 1) ? 8'ha0 : 8'($urandom);
      wr(`OSCT_ADDR_TUNE, tune_v);
      chk({2'b0, TRIM_HF}, {2'b0, tune_v[5:0]});
      chk({2'b0, TRIM_MF}, {2'b0, tune_v[5:0]});
      rd(`OSCT_ADDR_TUNE, tune_v);
      step(5'h04);
      step(5'h00);
      chk1(LF_TIMER_EN, 1'b1);
    end
    wr(2'h3, 8'hff);
    rd(`OSCT_ADDR_TUNE, tune_v);
    // Pin roles and multiplier enable over every mode and enable pair
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge CLK);
        OSC_MODE_CFG <= modes[m];
        PLL_CFG_EN   <= c[0];
        wr(`OSCT_ADDR_TUNE, {1'b0, c[1], 6'h0});
        step(5'h0);
        chk1(PLL_ACTIVE, (m == 0) ? (c[0] | c[1]) : c[1]);
        chk1(OSC_OUT_OE, m == 2);
        chk1(OSC_OUT_GPIO, m == 1);
        chk1(OSC_IN_GPIO, m != 0);
      end
    end
    // System source select: the chosen tick passes, another does not
    @(posedge CLK);
    OSC_MODE_CFG <= 4'h0;
    PLL_CFG_EN   <= 1'b0;
    wr(`OSCT_ADDR_TUNE, 8'h00);
    for (int s = 0; s < 3; s++) begin
      wr(`OSCT_ADDR_CTRL, {1'b0, OSCT_F16M, 2'b0, 2'(s)});
      q_v = OSC_OUT_O;
      step(5'(1 << bad[s]));
      step(5'h0);
      chk1(SYS_CLK_EN, 1'b0);
      step(5'(1 << src[s]));
      step(5'h0);
      chk1(SYS_CLK_EN, 1'b1);
      // Two system ticks flip the divide-by-four level
      step(5'(1 << src[s]));
      step(5'h0);
      chk1(OSC_OUT_O, ~q_v);
    end
    // Divider taps: 64 high ticks give 64 >> (7 - code) output ticks
    for (int f = 7; f > 0; f--) begin
      wr(`OSCT_ADDR_CTRL, {1'b0, 3'(f), 4'h0});
      run(0, 64, 4, 4);
      chk(8'(ni), 8'(64 >> (7 - f)));
    end
    // Mid oscillator paths and the low-frequency source bit
    wr(`OSCT_ADDR_CTRL2, 8'h01);
    wr(`OSCT_ADDR_CTRL, {1'b0, OSCT_F500, 4'h0});
    run(1, 8, 4, 4);
    chk(8'(ni), 8'd8);
    wr(`OSCT_ADDR_CTRL, {1'b0, OSCT_F31, 4'h0});
    wr(`OSCT_ADDR_TUNE, 8'h80);
    run(1, 32, 4, 4);
    chk(8'(ni), 8'd2);
    wr(`OSCT_ADDR_TUNE, 8'h00);
    run(2, 8, 4, 4);
    chk(8'(ni), 8'd8);
    // Times four on the external primary path, input ticks 16 cycles apart
    wr(`OSCT_ADDR_CTRL, 8'h00);
    @(posedge CLK);
    PLL_CFG_EN <= 1'b1;
    run(3, 4, 16, 0);
    run(3, 8, 16, 0);
    chk(8'(ns), 8'd32);
    // Times four on the internal primary path, high ticks 16 cycles apart
    wr(`OSCT_ADDR_CTRL, {1'b0, OSCT_F16M, 4'h0});
    @(posedge CLK);
    OSC_MODE_CFG <= `OSCT_MODE_INTIO;
    wr(`OSCT_ADDR_TUNE, 8'h40);
    run(0, 4, 16, 0);
    run(0, 8, 16, 0);
    chk(8'(ns), 8'd32);
    final_report();
  end
endmodule
`default_nettype wire
